// ---- src/sts_consts.vh ----
/*
  constants for the smbus temperature sensor front end: addresses,
  command codes, conversion timing and temperature encoding limits.
  assumes a 20 MHz system clock.
*/
`ifndef STS_CONSTS_VH
`define STS_CONSTS_VH
`define STS_ARA_ADDR 7'h0C
`define STS_CMD_LOCAL 8'h00
`define STS_CMD_REMOTE 8'h01
`define STS_CMD_ONESHOT 8'h0F
`define STS_CMD_RESET 8'h00
`define STS_TEMP_RESET 8'h00
`define STS_CLK_HZ 20000000
`define STS_CONV_MS 125
`define STS_CONV_CYCLES ((`STS_CLK_HZ / 1000) * `STS_CONV_MS)
`define STS_TEMP_MAX 8'h7F
`define STS_TEMP_MIN 8'h80
`endif

// ---- src/sts_bit_slave.v ----
/*
  smbus byte-level slave engine: detects start/stop, shifts bytes msb
  first, drives ack and read data on the open-drain data line.
  assumes scl and sda inputs are already synchronous to clock_i.
*/
`timescale 1ns/1ps
`include "sts_consts.vh"
module sts_bit_slave (
  input wire clock_i,
  input wire nrst_i,
  input wire scl_i,
  input wire sda_i,
  input wire ack_en_i,
  input wire [7:0] tx_byte_i,
  input wire tx_mode_i,
  output reg sda_oe_o,
  output reg start_o,
  output reg stop_o,
  output reg byte_o,
  output reg [7:0] rx_byte_o,
  output reg master_ack_o
);
  reg scl_q, sda_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg active_q;
  reg txing_q;
  wire scl_rise = scl_i & ~scl_q;
  wire scl_fall = ~scl_i & scl_q;
  wire st = scl_i & scl_q & sda_q & ~sda_i;
  wire sp = scl_i & scl_q & ~sda_q & sda_i;
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      active_q <= 1'b0;
      txing_q <= 1'b0;
      sda_oe_o <= 1'b0;
      start_o <= 1'b0;
      stop_o <= 1'b0;
      byte_o <= 1'b0;
      rx_byte_o <= 8'h00;
      master_ack_o <= 1'b0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      start_o <= st;
      stop_o <= sp;
      byte_o <= 1'b0;
      if (st) begin
        active_q <= 1'b1;
        cnt_q <= 4'h0;
        txing_q <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (sp) begin
        active_q <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (active_q && scl_rise) begin
        if (cnt_q < 4'h8) begin
          // read data moves out on falling edges only
          if (!txing_q) begin
            sh_q <= {sh_q[6:0], sda_i};
          end
          if (cnt_q == 4'h7 && !txing_q) begin
            rx_byte_o <= {sh_q[6:0], sda_i};
            byte_o <= 1'b1;
          end
        end else begin
          master_ack_o <= ~sda_i;
          if (txing_q) begin
            byte_o <= 1'b1;
          end
        end
        cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      end else if (active_q && scl_fall) begin
        // cnt_q already advanced: 8 means ack slot, 0 means next byte
        if (cnt_q == 4'h8) begin
          sda_oe_o <= txing_q ? 1'b0 : ack_en_i;
        end else if (cnt_q == 4'h0 && tx_mode_i && !txing_q && sda_oe_o) begin
          txing_q <= 1'b1;
          sh_q <= {tx_byte_i[6:0], 1'b0};
          sda_oe_o <= ~tx_byte_i[7];
        end else if (txing_q && cnt_q != 4'h0) begin
          sda_oe_o <= ~sh_q[7];
          sh_q <= {sh_q[6:0], 1'b0};
        end else begin
          sda_oe_o <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- src/sts_slave_top.v ----
/*
  smbus slave interface and conversion control of a two-channel
  temperature sensor. assumes synchronous pin inputs at 20 MHz; the
  analogue converter answers a start pulse with raw results in halves
  of a degree (9-bit two's complement) and a done pulse.
*/
// Notes on behaviour
// [R1] one-shot still converts once during software standby
// [R2] low standby input forces hardware standby
// [R3] standby input low blocks every software conversion request
// [R4] standby during conversion aborts it; result registers keep old values
// [R5] every conversion not aborted by standby lasts 125 ms from the conversion timer
// [R6] both channels answer at the single slave address
// [R7] write byte, read byte, send byte, receive byte supported
// [R8] receive byte returns register chosen by last command byte
// [R9] temperature is 8-bit two's complement, 1 degree per count, msb first
// [R10] half a degree added before truncation
// [R11] host frames; device returns read data, host does not ack it
// [R12] one-shot uses send byte; device acks address and command
// [R13] receive byte to alert response address returns own address
// [R14] multi-master hosts should avoid short protocols
// [R15] one-shot in hardware standby starts nothing
// [R16] after one-shot in software standby, return to standby
// [R17] one-shot during a running conversion is ignored
// [R18] command index resets to zero so first receive reads local
// [R19] foreign address is not acknowledged; transaction ignored
`timescale 1ns/1ps
`include "sts_consts.vh"
module sts_slave_top #(
  parameter [6:0] SLAVE_ADDR = 7'h18,
  parameter [31:0] CONV_CYCLES = `STS_CONV_CYCLES
) (
  input wire clock_i,
  input wire nrst_i,
  input wire scl_i,
  input wire sda_i,
  input wire standby_input_pin_i,
  input wire sw_standby_i,
  input wire alert_pending_i,
  input wire signed [8:0] raw_local_i,
  input wire signed [8:0] raw_remote_i,
  input wire adc_done_i,
  output reg sda_o,
  output reg sda_oe_o,
  output reg adc_start_o,
  output reg adc_abort_o,
  output reg busy_o,
  output reg [7:0] local_temp_o,
  output reg [7:0] remote_temp_o,
  output reg [7:0] cmd_index_o,
  output reg wr_strobe_o,
  output reg [7:0] wr_data_o
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_ADDR = 5'b00010;
  localparam [4:0] S_CMD = 5'b00100;
  localparam [4:0] S_DATA = 5'b01000;
  localparam [4:0] S_SKIP = 5'b10000;

  wire oe_w, st_w, sp_w, byte_w, mack_w;
  wire [7:0] rx_w;
  reg [4:0] st_q;
  reg ack_en_q;
  reg tx_mode_q;
  reg ara_q;
  reg [7:0] tx_byte_q;
  reg oneshot_q;
  reg conv_q;
  reg [31:0] tmr_q;
  reg busy_shot_q;

  sts_bit_slave u_bit (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ack_en_i(ack_en_q),
    .tx_byte_i(tx_byte_q),
    .tx_mode_i(tx_mode_q),
    .sda_oe_o(oe_w),
    .start_o(st_w),
    .stop_o(sp_w),
    .byte_o(byte_w),
    .rx_byte_o(rx_w),
    .master_ack_o(mack_w)
  );

  // rounding: add half degree then drop the fraction, clamp to 8 bits
  function [7:0] round_temp;
    input signed [8:0] raw;
    reg signed [9:0] s;
    begin
      s = {raw[8], raw} + 10'sd1; // R10
      s = s >>> 1;
      if (s > 10'sd127)
        round_temp = `STS_TEMP_MAX;
      else if (s < -10'sd128)
        round_temp = `STS_TEMP_MIN;
      else
        round_temp = s[7:0]; // R9
    end
  endfunction

  // register read mux; index shared by both channels
  always @* begin
    case (cmd_index_o)
      `STS_CMD_LOCAL: tx_byte_q = local_temp_o;
      `STS_CMD_REMOTE: tx_byte_q = remote_temp_o;
      default: tx_byte_q = 8'h00;
    endcase
    if (ara_q)
      tx_byte_q = {SLAVE_ADDR, 1'b1}; // R13
  end

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= S_IDLE;
      ack_en_q <= 1'b0;
      tx_mode_q <= 1'b0;
      ara_q <= 1'b0;
      cmd_index_o <= `STS_CMD_RESET; // R18
      wr_strobe_o <= 1'b0;
      wr_data_o <= 8'h00;
      oneshot_q <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= oe_w;
      wr_strobe_o <= 1'b0;
      oneshot_q <= 1'b0;
      if (st_w) begin
        st_q <= S_ADDR;
        ack_en_q <= 1'b0;
        tx_mode_q <= 1'b0;
        ara_q <= 1'b0;
      end else if (sp_w) begin
        st_q <= S_IDLE;
        tx_mode_q <= 1'b0;
        ack_en_q <= 1'b0;
      end else if (byte_w) begin
        case (st_q)
          S_ADDR: begin
            if (rx_w[7:1] == SLAVE_ADDR) begin // R6
              ack_en_q <= 1'b1;
              tx_mode_q <= rx_w[0];
              st_q <= rx_w[0] ? S_SKIP : S_CMD; // R8
            end else if (rx_w[7:1] == `STS_ARA_ADDR && rx_w[0] && alert_pending_i) begin
              ack_en_q <= 1'b1;
              tx_mode_q <= 1'b1;
              ara_q <= 1'b1; // R13
              st_q <= S_SKIP;
            end else begin
              ack_en_q <= 1'b0; // R19
              st_q <= S_SKIP;
            end
          end
          S_CMD: begin
            if (rx_w == `STS_CMD_ONESHOT)
              oneshot_q <= 1'b1; // R12
            else
              cmd_index_o <= rx_w; // R7
            st_q <= S_DATA;
          end
          S_DATA: begin
            wr_data_o <= rx_w; // R7
            wr_strobe_o <= 1'b1;
            st_q <= S_SKIP;
          end
          S_SKIP: begin
            // read byte done (master nack ends it) or extra bytes refused
            ack_en_q <= 1'b0; // R11
            tx_mode_q <= tx_mode_q & mack_w;
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // conversion control
  wire hw_standby_input_pin = ~standby_input_pin_i; // R2
  wire standby_input_pin = hw_standby_input_pin | sw_standby_i;
  wire auto_req = ~standby_input_pin & ~conv_q & (tmr_q == 32'd0);
  wire shot_req = oneshot_q & ~hw_standby_input_pin & ~conv_q; // R1 R3 R15 R17

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_q <= 1'b0;
      tmr_q <= 32'd0;
      adc_start_o <= 1'b0;
      adc_abort_o <= 1'b0;
      busy_o <= 1'b0;
      local_temp_o <= `STS_TEMP_RESET;
      remote_temp_o <= `STS_TEMP_RESET;
    end else begin
      adc_start_o <= 1'b0;
      adc_abort_o <= 1'b0;
      if (conv_q && standby_input_pin && !busy_shot_q) begin
        conv_q <= 1'b0; // R4
        adc_abort_o <= 1'b1;
        tmr_q <= 32'd0;
      end else if (conv_q && hw_standby_input_pin) begin
        conv_q <= 1'b0; // R4
        adc_abort_o <= 1'b1;
        tmr_q <= 32'd0;
      end else if (conv_q) begin
        if (adc_done_i) begin
          local_temp_o <= round_temp(raw_local_i);
          remote_temp_o <= round_temp(raw_remote_i);
        end
        if (tmr_q == CONV_CYCLES - 32'd1) begin
          conv_q <= 1'b0; // R5 R16
          tmr_q <= 32'd0;
        end else begin
          tmr_q <= tmr_q + 32'd1;
        end
      end else if (auto_req || shot_req) begin
        conv_q <= 1'b1;
        adc_start_o <= 1'b1;
        tmr_q <= 32'd0;
      end
      busy_o <= conv_q;
    end
  end

  // one-shot in software standby survives the software standby level
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i)
      busy_shot_q <= 1'b0;
    else if (shot_req && !auto_req)
      busy_shot_q <= 1'b1; // R1
    else if (!conv_q)
      busy_shot_q <= 1'b0;
  end
endmodule

// ---- test/sts_slave_top_properties.sv ----
/* port assertions for sts_slave_top;
   bound to every instance, sized by its CONV_CYCLES */
`timescale 1ns/1ps
module sts_slave_chk #(
  parameter [31:0] CONV_CYCLES = 32'd50
) (
  input wire clock_i,
  input wire nrst_i,
  input wire scl_i,
  input wire standby_input_pin_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire adc_start_o,
  input wire adc_abort_o,
  input wire busy_o,
  input wire [7:0] local_temp_o,
  input wire [7:0] remote_temp_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  reg [31:0] busy_q;
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) busy_q <= 32'h0;
    else busy_q <= busy_o ? busy_q + 32'h1 : 32'h0;
  end
  sequence s_kept;
    ($stable(local_temp_o) && $stable(remote_temp_o)) [*4];
  endsequence
  sequence s_low;
    !standby_input_pin_i && !$past(standby_input_pin_i) && !$past(standby_input_pin_i, 2);
  endsequence
  chk_sda_open: assert property (sda_o == 1'b0)
    else $error("sda high");
  chk_hw_block: assert property (s_low |-> !adc_start_o)
    else $error("start in standby");
  chk_busy_start: assert property (adc_start_o |-> ##[1:2] busy_o)
    else $error("no busy");
  chk_no_restart: assert property (busy_q > 2 && busy_q < CONV_CYCLES - 2 |-> !adc_start_o)
    else $error("restart");
  chk_conv_len: assert property (busy_q <= CONV_CYCLES + 2)
    else $error("long conversion");
  chk_abort_hw: assert property (busy_o && $fell(standby_input_pin_i)
    && busy_q < CONV_CYCLES - 4 |-> ##[0:3] adc_abort_o)
    else $error("no abort");
  chk_abort_keep: assert property (adc_abort_o |=> s_kept)
    else $error("result changed");
  chk_ack_edge: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("sda moved in high");
endmodule
bind sts_slave_top sts_slave_chk #(.CONV_CYCLES(CONV_CYCLES)) i_chk (.clock_i, .nrst_i,
  .scl_i, .standby_input_pin_i, .sda_o, .sda_oe_o, .adc_start_o, .adc_abort_o, .busy_o,
  .local_temp_o, .remote_temp_o);

// ---- test/sts_host_model.sv ----
/* smbus host master model, one phase per four clocks;
   sda_i is the resolved line with its pull-up */
`timescale 1ns/1ps
module sts_host_model (
  input wire clock_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_low_o
);
  initial scl_o = 1'b1;
  initial sda_low_o = 1'b0;
  task automatic hw(input integer n);
    repeat (n) @(posedge clock_i);
  endtask
  task st(input c, input l);
    scl_o <= c;
    sda_low_o <= l;
    hw(4);
  endtask
  task start;
    st(scl_o, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
    st(1'b0, 1'b1);
  endtask
  task stop;
    st(1'b0, 1'b1);
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
  endtask
  // nine bits msb first, last is the ack slot
  task xb(input [8:0] d, output [8:0] q);
    integer i;
    for (i = 8; i >= 0; i = i - 1) begin
      st(1'b0, !d[i]);
      st(1'b1, !d[i]);
      q[i] = sda_i;
      st(1'b1, !d[i]);
      st(1'b0, !d[i]);
    end
  endtask
endmodule

// ---- test/smbus_temp_sensor_interface_tb.sv ----
/* bench for sts_slave_top with host and converter models;
   checker bound from its own file */
`timescale 1ns/1ps
`include "sts_consts.vh"
module smbus_temp_sensor_interface_tb;
  localparam [6:0] AD = 7'h18;
  reg clock_i = 1'b0;
  reg nrst_i = 1'b0;
  reg pin = 1'b1;
  reg alert = 1'b0;
  reg done = 1'b0;
  reg [8:0] rl = 9'h000;
  reg [8:0] rr = 9'h000;
  reg [7:0] seen = 8'h00;
  reg sw = 1'b1;
  wire scl, hl, oe, go, ab, busy, ws, so;
  wire [7:0] wd, lt, rt, ci;
  wire sda = !(hl | oe);
  integer failures = 0, n_tests = 0, ns = 0, na = 0, cnt = 0;
  always #25 clock_i = ~clock_i;
  sts_host_model i_host (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(hl));
  sts_slave_top #(.SLAVE_ADDR(AD), .CONV_CYCLES(32'd1000)) i_dut (.clock_i(clock_i),
    .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .standby_input_pin_i(pin),
    .sw_standby_i(sw), .alert_pending_i(alert), .raw_local_i(rl), .raw_remote_i(rr),
    .adc_done_i(done), .sda_o(so), .sda_oe_o(oe), .adc_start_o(go), .adc_abort_o(ab),
    .busy_o(busy), .local_temp_o(lt), .remote_temp_o(rt), .cmd_index_o(ci),
    .wr_strobe_o(ws), .wr_data_o(wd));
  // converter answers halfway through the window
  always @(posedge clock_i) begin
    cnt <= go ? 500 : (ab ? 0 : (cnt > 0 ? cnt - 1 : 0));
    done <= cnt == 1;
    ns <= ns + go;
    na <= na + ab;
    if (ws) seen <= wd;
  end
  task chk(input string w, input [7:0] e, input [7:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("Error %0s expected %h seen %h", w, e, g);
    end
  endtask
  task put(input [7:0] b, input e);
    reg [8:0] q;
    i_host.xb({b, 1'b1}, q);
    chk("ack", {7'h00, e}, {7'h00, q[0]});
  endtask
  task wr(input [7:0] c, input [8:0] d, input more);
    i_host.start;
    put({AD, 1'b0}, 1'b0);
    put(c, 1'b0);
    if (d[8]) put(d[7:0], 1'b0);
    if (!more) i_host.stop;
  endtask
  task rcv(input [6:0] a, input [7:0] e, input nak);
    reg [8:0] q;
    i_host.start;
    put({a, 1'b1}, nak);
    i_host.xb(9'h1FF, q);
    if (!nak) chk("data", e, q[8:1]);
    i_host.stop;
  endtask
  task t_round(input [8:0] l, input [8:0] r, input [7:0] el, input [7:0] er);
    integer n, k;
    n = ns;
    rl <= l;
    rr <= r;
    wr(`STS_CMD_ONESHOT, 9'h000, 1'b0);
    wr(`STS_CMD_ONESHOT, 9'h000, 1'b0);
    for (k = 0; k < 4000 && busy !== 1'b0; k = k + 1) i_host.hw(1);
    i_host.hw(200);
    n = ns - n;
    chk("starts", 8'h01, n[7:0]);
    chk("busy", 8'h00, {7'h00, busy});
    chk("local", el, lt);
    chk("remote", er, rt);
    wr(`STS_CMD_LOCAL, 9'h000, 1'b1);
    rcv(AD, el, 1'b0);
    wr(`STS_CMD_REMOTE, 9'h000, 1'b1);
    chk("index", `STS_CMD_REMOTE, ci);
    rcv(AD, er, 1'b0);
    rcv(AD, er, 1'b0);
  endtask
  task t_hw;
    integer n;
    rl <= 9'h0FD;
    wr(`STS_CMD_ONESHOT, 9'h000, 1'b0);
    i_host.hw(100);
    pin <= 1'b0;
    n = ns;
    i_host.hw(10);
    chk("aborts", 8'h01, na[7:0]);
    wr(`STS_CMD_ONESHOT, 9'h000, 1'b0);
    i_host.hw(600);
    n = ns - n;
    chk("starts", 8'h00, n[7:0]);
    wr(`STS_CMD_LOCAL, 9'h000, 1'b1);
    rcv(AD, 8'h01, 1'b0);
    pin <= 1'b1;
  endtask
  // auto conversions, then software standby cuts the second one short
  task t_sw;
    integer n, a, k;
    n = ns;
    a = na;
    rl <= 9'h032;
    rr <= 9'h1CE;
    sw <= 1'b0;
    i_host.hw(900);
    k = ns - n;
    chk("auto starts", 8'h01, k[7:0]);
    i_host.hw(200);
    k = ns - n;
    chk("auto starts", 8'h02, k[7:0]);
    rl <= 9'h0FF;
    rr <= 9'h0FF;
    sw <= 1'b1;
    i_host.hw(10);
    k = na - a;
    chk("sw aborts", 8'h01, k[7:0]);
    chk("local", 8'h19, lt);
    chk("remote", 8'hE7, rt);
    i_host.hw(600);
    k = ns - n;
    chk("starts", 8'h02, k[7:0]);
  endtask
  task finish_test;
    $display("failures %0d tests %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    i_host.hw(4);
    nrst_i <= 1'b1;
    i_host.hw(2);
    rcv(AD, 8'h00, 1'b0);
    chk("sda_o", 8'h00, {7'h00, so});
    t_round(9'h0FF, 9'h192, 8'h7F, 8'hC9);
    t_round(9'h001, 9'h1FF, 8'h01, 8'h00);
    t_hw;
    t_sw;
    rcv(7'h2A, 8'h00, 1'b1);
    alert <= 1'b1;
    rcv(`STS_ARA_ADDR, {AD, 1'b1}, 1'b0);
    alert <= 1'b0;
    wr(8'h0B, 9'h15A, 1'b0);
    chk("write", 8'h5A, seen);
    chk("index", 8'h0B, ci);
    finish_test;
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    failures = failures + 1;
    finish_test;
  end
endmodule
